// ===== logic/rtcfe_defs.vh
// Purpose: shared constants of the three-wire calendar clock front end
// Assumes: 125 MHz system clock
// Notes: timing counts derive from the figures in their own units
`ifndef RTCFE_DEFS_VH
`define RTCFE_DEFS_VH

// system clock and crystal rate
`define RTCFE_CLK_HZ 125000000
`define RTCFE_XTAL_HZ 32768
// command phase and data byte length
`define RTCFE_CMD_BITS 8
`define RTCFE_BYTE_BITS 8
// command fields: top nibble fixed code, next three select, last read flag
`define RTCFE_CMD_CODE 4'h6
`define RTCFE_CMD_CODE_MSB 7
`define RTCFE_CMD_CODE_LSB 4
`define RTCFE_CMD_SEL_MSB 3
`define RTCFE_CMD_SEL_LSB 1
`define RTCFE_CMD_RD_BIT 0
// command selects
`define RTCFE_SEL_STAT1 3'h0
`define RTCFE_SEL_STAT2 3'h1
`define RTCFE_SEL_SEC 3'h2
`define RTCFE_SEL_MIN 3'h3
`define RTCFE_SEL_HOUR 3'h4
`define RTCFE_SEL_DAY 3'h5
`define RTCFE_SEL_MON 3'h6
`define RTCFE_SEL_YEAR 3'h7
// interrupt source encodings in status 2 bits 2:0
`define RTCFE_INT_ALARM1 3'h0
`define RTCFE_INT_ALARM2 3'h1
`define RTCFE_INT_USERF 3'h2
`define RTCFE_INT_MIN1 3'h3
`define RTCFE_INT_MIN2 3'h4
`define RTCFE_INT_XTAL 3'h5
// status 1 field positions
`define RTCFE_ST1_POWERON 0
`define RTCFE_ST1_LOWVDD 1
// reset values
`define RTCFE_STAT2_RST 8'h00
`define RTCFE_DAY_RST 5'h01
`define RTCFE_MON_RST 4'h1
// calendar limit: last year kept is 2099
`define RTCFE_YEAR_LAST 7'h63

`endif

// ===== logic/rtcfe_sync.v
// Purpose: two-flop synchroniser for pin inputs
// Assumes: single destination clock
// Notes: first stage read only by second stage
module rtcfe_sync #(
  parameter WIDTH = 1
) (
  input wire clock_i,
  input wire rst_i,
  input wire [WIDTH-1:0] async_i,
  output reg [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] stage;

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      stage <= {WIDTH{1'b0}};
      sync_o <= {WIDTH{1'b0}};
    end else begin
      stage <= async_i;
      sync_o <= stage;
    end
  end
endmodule

// ===== logic/rtcfe_calendar.v
// Purpose: time of day and calendar counters up to the year 2099
// Assumes: sec_tick_i is a one-cycle pulse once per second
// Notes: binary fields; year counts 0..99 from 2000
`include "rtcfe_defs.vh"
module rtcfe_calendar (
  input wire clock_i,
  input wire rst_i,
  input wire sec_tick_i,
  input wire wr_en_i,
  input wire [2:0] wr_sel_i,
  input wire [7:0] wr_data_i,
  output reg [5:0] sec_o,
  output reg [5:0] min_o,
  output reg [4:0] hour_o,
  output reg [4:0] day_o,
  output reg [3:0] mon_o,
  output reg [6:0] year_o,
  output reg min_tick_o
);
  // days in month with leap rule; every fourth year within 2000..2099
  function [4:0] rtcfe_mdays;
    input [3:0] m;
    input [6:0] y;
    begin
      case (m)
        4'h2: rtcfe_mdays = (y[1:0] == 2'h0) ? 5'h1d : 5'h1c;
        4'h4, 4'h6, 4'h9, 4'hb: rtcfe_mdays = 5'h1e;
        default: rtcfe_mdays = 5'h1f;
      endcase
    end
  endfunction

  wire end_sec = (sec_o == 6'h3b);
  wire end_min = end_sec && (min_o == 6'h3b);
  wire end_hour = end_min && (hour_o == 5'h17);
  wire end_day = end_hour && (day_o == rtcfe_mdays(mon_o, year_o));
  wire end_mon = end_day && (mon_o == 4'hc);

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sec_o <= 6'h00;
      min_o <= 6'h00;
      hour_o <= 5'h00;
      day_o <= `RTCFE_DAY_RST;
      mon_o <= `RTCFE_MON_RST;
      year_o <= 7'h00;
      min_tick_o <= 1'b0;
    end else begin
      min_tick_o <= sec_tick_i && end_sec;
      if (wr_en_i) begin
        case (wr_sel_i)
          `RTCFE_SEL_SEC: sec_o <= wr_data_i[5:0];
          `RTCFE_SEL_MIN: min_o <= wr_data_i[5:0];
          `RTCFE_SEL_HOUR: hour_o <= wr_data_i[4:0];
          `RTCFE_SEL_DAY: day_o <= wr_data_i[4:0];
          `RTCFE_SEL_MON: mon_o <= wr_data_i[3:0];
          `RTCFE_SEL_YEAR: year_o <= wr_data_i[6:0];
          default: sec_o <= sec_o;
        endcase
      end else if (sec_tick_i) begin
        // automatic advance with leap days
        sec_o <= end_sec ? 6'h00 : sec_o + 6'h01;
        if (end_sec) min_o <= end_min ? 6'h00 : min_o + 6'h01;
        if (end_min) hour_o <= end_hour ? 5'h00 : hour_o + 5'h01;
        if (end_hour) day_o <= end_day ? 5'h01 : day_o + 5'h01;
        if (end_day) mon_o <= end_mon ? 4'h1 : mon_o + 4'h1;
        if (end_mon) year_o <= (year_o == `RTCFE_YEAR_LAST) ? 7'h00 : year_o + 7'h01;
      end
    end
  end
endmodule

// ===== logic/rtcfe_top.v
// Purpose: pin front end of a three-wire calendar clock
// Assumes: clock_i 125 MHz, far faster than serial clock and crystal
// Notes: select, serial clock, data, crystal and low supply pins pass two flip-flops; open-drain pins drive low only
`include "rtcfe_defs.vh"

////////////////////////////////////////////////////////////////////////
// Operation
// - transfers only while select is high
// - serial clock ignored while select low
// - one data bit per serial clock cycle: taken on the rising edge, presented on the falling edge
// - data line released while select low
// - select rise starts receive command phase
// - data line driven low only, read back
// - status 2 picks interrupt pin source
// - interrupt pin open-drain, pulls low asserting
// - calendar advances through 2099 with leaps
// - flag set on power-on and low supply
// - timekeeping from own crystal only
module rtcfe_top (
  input wire clock_i,
  input wire rst_i,
  input wire chip_sel_i,
  input wire serial_clk_i,
  input wire bidir_serial_line_i,
  input wire crystal_in_i,
  input wire low_supply_i,
  input wire alarm1_i,
  input wire alarm2_i,
  input wire user_freq_i,
  output reg bidir_serial_line_o,
  output reg bidir_serial_line_oe_o,
  output reg int_n_o,
  output reg int_n_oe_o,
  output reg crystal_drive_out_o
);
  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  wire [4:0] pins_s;
  rtcfe_sync #(
    .WIDTH(5)
  ) u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .async_i({chip_sel_i, serial_clk_i, bidir_serial_line_i, crystal_in_i, low_supply_i}),
    .sync_o(pins_s)
  );
  wire sel_s = pins_s[4];
  wire sck_s = pins_s[3];
  wire sio_s = pins_s[2];
  wire xtal_s = pins_s[1];
  wire lowv_s = pins_s[0];

  // rising edge of a synchronised level against its delayed copy
  function rtcfe_rise;
    input cur;
    input old;
    begin
      rtcfe_rise = cur && !old;
    end
  endfunction

  reg sel_d;
  reg sck_d;
  reg xtal_d;
  wire sel_rise = rtcfe_rise(sel_s, sel_d);
  // only edges seen while selected count
  wire sck_rise = sel_s && rtcfe_rise(sck_s, sck_d);
  wire sck_fall = sel_s && rtcfe_rise(sck_d, sck_s);

  ////////////////////////////////////////////////////////////////////////
  // crystal divider: one pulse per second from 32768 crystal cycles
  reg [14:0] xdiv;
  reg sec_tick;
  wire xtal_rise = rtcfe_rise(xtal_s, xtal_d);

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sel_d <= 1'b0;
      sck_d <= 1'b0;
      xtal_d <= 1'b0;
      xdiv <= 15'h0000;
      sec_tick <= 1'b0;
      crystal_drive_out_o <= 1'b0;
    end else begin
      sel_d <= sel_s;
      sck_d <= sck_s;
      xtal_d <= xtal_s;
      crystal_drive_out_o <= !xtal_s;
      // time base is the crystal, never the serial clock
      sec_tick <= xtal_rise && (xdiv == 15'h7fff);
      if (xtal_rise) xdiv <= xdiv + 15'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status registers and calendar
  reg [7:0] stat2;
  reg poweron;
  reg lowv_flag;
  reg [7:0] shreg;
  reg [3:0] bitcnt;
  reg [1:0] state;
  reg [2:0] cmd_sel;
  reg wr_pulse;
  reg st1_rd;
  wire min_tick;
  wire [5:0] cal_sec;
  wire [5:0] cal_min;
  wire [4:0] cal_hour;
  wire [4:0] cal_day;
  wire [3:0] cal_mon;
  wire [6:0] cal_year;

  rtcfe_calendar u_cal (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .sec_tick_i(sec_tick),
    .wr_en_i(wr_pulse),
    .wr_sel_i(cmd_sel),
    .wr_data_i(shreg),
    .sec_o(cal_sec),
    .min_o(cal_min),
    .hour_o(cal_hour),
    .day_o(cal_day),
    .mon_o(cal_mon),
    .year_o(cal_year),
    .min_tick_o(min_tick)
  );

  // a status 1 read stays marked until the select falls
  wire stat1_read = st1_rd;

  // power-on and low supply flags, cleared by reading status 1, set wins
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      poweron <= 1'b1;
      lowv_flag <= 1'b0;
      stat2 <= `RTCFE_STAT2_RST;
    end else begin
      if (stat1_read && !sel_s) begin
        poweron <= 1'b0;
      end
      // low supply sets the flag regardless of a clear
      if (lowv_s) begin
        lowv_flag <= 1'b1;
      end else if (stat1_read && !sel_s) begin
        lowv_flag <= 1'b0;
      end
      if (wr_pulse && cmd_sel == `RTCFE_SEL_STAT2) stat2 <= shreg;
    end
  end

  // read data for a selected register
  function [7:0] rtcfe_rdata;
    input [2:0] s;
    input [7:0] st1;
    input [7:0] st2;
    input [47:0] cal;
    begin
      case (s)
        `RTCFE_SEL_STAT1: rtcfe_rdata = st1;
        `RTCFE_SEL_STAT2: rtcfe_rdata = st2;
        `RTCFE_SEL_SEC: rtcfe_rdata = {2'h0, cal[5:0]};
        `RTCFE_SEL_MIN: rtcfe_rdata = {2'h0, cal[13:8]};
        `RTCFE_SEL_HOUR: rtcfe_rdata = {3'h0, cal[20:16]};
        `RTCFE_SEL_DAY: rtcfe_rdata = {3'h0, cal[28:24]};
        `RTCFE_SEL_MON: rtcfe_rdata = {4'h0, cal[35:32]};
        default: rtcfe_rdata = {1'b0, cal[46:40]};
      endcase
    end
  endfunction

  // select field of a command whose last bit is still on the line
  function [2:0] rtcfe_cmd_sel;
    input [7:0] sh;
    begin
      rtcfe_cmd_sel = sh[`RTCFE_CMD_SEL_MSB-1:`RTCFE_CMD_SEL_LSB-1];
    end
  endfunction

  // fixed code field of the same partial command
  function rtcfe_cmd_ok;
    input [7:0] sh;
    begin
      rtcfe_cmd_ok = (sh[`RTCFE_CMD_CODE_MSB-1:`RTCFE_CMD_CODE_LSB-1] == `RTCFE_CMD_CODE);
    end
  endfunction

  wire [7:0] st1_val = {6'h00, lowv_flag, poweron};
  wire [47:0] cal_pack = {1'b0, cal_year, 4'h0, cal_mon, 3'h0, cal_day,
                          3'h0, cal_hour, 2'h0, cal_min, 2'h0, cal_sec};

  ////////////////////////////////////////////////////////////////////////
  // serial engine
  localparam ST_IDLE = 2'h0;
  localparam ST_CMD = 2'h1;
  localparam ST_WRITE = 2'h2;
  localparam ST_READ = 2'h3;

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      cmd_sel <= 3'h0;
      st1_rd <= 1'b0;
      wr_pulse <= 1'b0;
      bidir_serial_line_o <= 1'b0;
      bidir_serial_line_oe_o <= 1'b0;
    end else begin
      wr_pulse <= 1'b0;
      bidir_serial_line_o <= 1'b0;
      if (!sel_s) begin
        // deselected: drop partial bits and release the line
        state <= ST_IDLE;
        bitcnt <= 4'h0;
        st1_rd <= 1'b0;
        bidir_serial_line_oe_o <= 1'b0;
      end else if (sel_rise) begin
        // new select opens in receive, command first
        state <= ST_CMD;
        bitcnt <= 4'h0;
        st1_rd <= 1'b0;
        bidir_serial_line_oe_o <= 1'b0;
      end else begin
        case (state)
          ST_CMD: begin
            if (sck_rise) begin
              // one bit per serial clock
              shreg <= {shreg[6:0], sio_s};
              bitcnt <= bitcnt + 4'h1;
              if (bitcnt == `RTCFE_CMD_BITS - 1) begin
                bitcnt <= 4'h0;
                cmd_sel <= rtcfe_cmd_sel(shreg);
                if (!rtcfe_cmd_ok(shreg)) begin
                  state <= ST_IDLE;
                end else if (sio_s) begin
                  state <= ST_READ;
                  st1_rd <= (rtcfe_cmd_sel(shreg) == `RTCFE_SEL_STAT1);
                  shreg <= rtcfe_rdata(rtcfe_cmd_sel(shreg), st1_val, stat2, cal_pack);
                end else begin
                  state <= ST_WRITE;
                end
              end
            end
          end
          ST_WRITE: begin
            if (sck_rise) begin
              shreg <= {shreg[6:0], sio_s};
              bitcnt <= bitcnt + 4'h1;
              if (bitcnt == `RTCFE_BYTE_BITS - 1) begin
                bitcnt <= 4'h0;
                wr_pulse <= 1'b1;
              end
            end
          end
          ST_READ: begin
            // present on falling edge, drive low only
            if (sck_fall) begin
              bidir_serial_line_oe_o <= !shreg[7];
              shreg <= {shreg[6:0], 1'b1};
              bitcnt <= bitcnt + 4'h1;
              if (bitcnt == `RTCFE_BYTE_BITS) begin
                bidir_serial_line_oe_o <= 1'b0;
                state <= ST_IDLE;
              end
            end
          end
          default: begin
            bidir_serial_line_oe_o <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt pin source select
  reg src;

  always @* begin
    // status 2 low bits pick the source
    case (stat2[2:0])
      `RTCFE_INT_ALARM1: src = alarm1_i;
      `RTCFE_INT_ALARM2: src = alarm2_i;
      `RTCFE_INT_USERF: src = user_freq_i;
      `RTCFE_INT_MIN1: src = min_tick;
      `RTCFE_INT_MIN2: src = min_tick || (cal_sec == 6'h1e && sec_tick);
      `RTCFE_INT_XTAL: src = xtal_s;
      default: src = 1'b0;
    endcase
  end

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      int_n_o <= 1'b0;
      int_n_oe_o <= 1'b0;
    end else begin
      // pull low to assert, float otherwise
      int_n_o <= 1'b0;
      int_n_oe_o <= src;
    end
  end
endmodule

// ===== verif/rtcfe_chk_asserts.sv
// Purpose: pin checks of the calendar clock front end
// Assumes: host keeps serial clock low between frames
// Notes: bound to rtcfe_top
module rtcfe_chk (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic chip_sel_i,
  input wire logic serial_clk_i,
  input wire logic crystal_in_i,
  input wire logic bidir_serial_line_o,
  input wire logic bidir_serial_line_oe_o,
  input wire logic int_n_o,
  input wire logic int_n_oe_o,
  input wire logic crystal_drive_out_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  a_line_low_only: assert property (bidir_serial_line_o == 1'b0)
    else $error("data line driven high");
  a_int_low_only: assert property (int_n_o == 1'b0)
    else $error("interrupt pin driven high");
  a_reset_quiet: assert property ($fell(rst_i) |-> !bidir_serial_line_oe_o && !int_n_oe_o)
    else $error("pins pulled after reset");
  a_idle_released: assert property (!chip_sel_i [*6] |-> !bidir_serial_line_oe_o)
    else $error("data line pulled while idle");
  a_cmd_receive: assert property ($rose(chip_sel_i) |=> !bidir_serial_line_oe_o [*8])
    else $error("data line pulled in command phase");
  a_drive_after_fall: assert property (
    $rose(bidir_serial_line_oe_o) |-> chip_sel_i && !serial_clk_i)
    else $error("data pulled outside serial clock low");
  a_oe_sck_low: assert property ($changed(bidir_serial_line_oe_o) |-> !serial_clk_i)
    else $error("data changed while serial clock high");
  a_xtal_follow: assert property (
    $stable(crystal_in_i) [*6] |-> crystal_drive_out_o == !crystal_in_i)
    else $error("crystal drive not inverted");
  cover property ($rose(bidir_serial_line_oe_o));
  cover property ($rose(int_n_oe_o));
  cover property ($rose(chip_sel_i));
endmodule
bind rtcfe_top rtcfe_chk chk_u (
  .clock_i(clock_i),
  .rst_i(rst_i),
  .chip_sel_i(chip_sel_i),
  .serial_clk_i(serial_clk_i),
  .crystal_in_i(crystal_in_i),
  .bidir_serial_line_o(bidir_serial_line_o),
  .bidir_serial_line_oe_o(bidir_serial_line_oe_o),
  .int_n_o(int_n_o),
  .int_n_oe_o(int_n_oe_o),
  .crystal_drive_out_o(crystal_drive_out_o)
);

// ===== verif/rtcfe_host_model.sv
// Purpose: host side of the three-wire port
// Assumes: data line has a pull-up
// Notes: serial clock half period 6 or 7 cycles
module rtcfe_host_model (
  input wire logic clock_i,
  input wire logic dev_oe_i,
  output logic chip_sel_o,
  output logic serial_clk_o,
  output wire logic line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pull_low = 1'b0;
  // pull-up unless either side pulls low
  assign line_o = !(dev_oe_i || pull_low);
  initial begin
    chip_sel_o = 1'b0;
    serial_clk_o = 1'b0;
  end
  task automatic half();
    repeat (6) @(posedge clock_i);
  endtask
  task automatic sel(input logic v);
    @(posedge clock_i);
    chip_sel_o <= v;
    pull_low <= 1'b0;
    half();
  endtask
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'hff;
    for (int i = 7; i > 7 - n; i--) begin
      @(posedge clock_i);
      pull_low <= !tx[i];
      half();
      serial_clk_o <= 1'b1;
      rx[i] = line_o;
      half();
      serial_clk_o <= 1'b0;
    end
  endtask
endmodule

// ===== verif/rtc_three_wire_pin_front_end_tb.sv
// Purpose: self-checking bench of the front end
// Assumes: interrupt sources assert high
// Notes: calendar rollover not exercised
`include "rtcfe_defs.vh"
module rtc_three_wire_pin_front_end_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0;
  logic rst_i;
  logic xtal;
  logic low_sup;
  logic alarm1;
  logic alarm2;
  logic user_freq;
  wire cs, sck, line, line_o, line_oe, int_o, int_oe, xdrv;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  always #4 clock_i = ~clock_i;
  rtcfe_top dut_u (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .chip_sel_i(cs),
    .serial_clk_i(sck),
    .bidir_serial_line_i(line),
    .crystal_in_i(xtal),
    .low_supply_i(low_sup),
    .alarm1_i(alarm1),
    .alarm2_i(alarm2),
    .user_freq_i(user_freq),
    .bidir_serial_line_o(line_o),
    .bidir_serial_line_oe_o(line_oe),
    .int_n_o(int_o),
    .int_n_oe_o(int_oe),
    .crystal_drive_out_o(xdrv)
  );
  rtcfe_host_model host_u (
    .clock_i(clock_i),
    .dev_oe_i(line_oe),
    .chip_sel_o(cs),
    .serial_clk_o(sck),
    .line_o(line)
  );
  ////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic access(input logic [2:0] s, input logic rd, input logic [7:0] wd,
                        output logic [7:0] rv);
    logic [7:0] junk;
    host_u.sel(1'b1);
    host_u.xfer({`RTCFE_CMD_CODE, s, rd}, 8, junk);
    host_u.xfer(rd ? 8'hff : wd, 8, rv);
    host_u.sel(1'b0);
  endtask
  ////////////////////////////////////////
  task automatic t_status();
    logic [7:0] v;
    check("oe after reset", 8'h00, {7'h0, line_oe});
    access(`RTCFE_SEL_STAT1, 1'b1, 8'h00, v);
    check("power-on flag", 8'h01, v);
    low_sup <= 1'b1;
    access(`RTCFE_SEL_STAT1, 1'b1, 8'h00, v);
    check("low supply flag", 8'h02, v);
    low_sup <= 1'b0;
  endtask
  task automatic t_int_source();
    logic [7:0] v;
    for (int s = 0; s < 6; s++) begin
      access(`RTCFE_SEL_STAT2, 1'b0, 8'(s), v);
      access(`RTCFE_SEL_STAT2, 1'b1, 8'h00, v);
      check("int source", 8'(s), v);
      if (s < 3) begin
        {user_freq, alarm2, alarm1} <= 3'h7 ^ (3'h1 << s);
        repeat (6) @(posedge clock_i);
        check("int idle", 8'h00, {7'h0, int_oe});
        {user_freq, alarm2, alarm1} <= 3'h1 << s;
        repeat (6) @(posedge clock_i);
        check("int asserted", 8'h01, {7'h0, int_oe});
        {user_freq, alarm2, alarm1} <= 3'h0;
      end
    end
  endtask
  task automatic t_xtal();
    for (int k = 0; k < 4; k++) begin
      xtal <= ~xtal;
      repeat (8) @(posedge clock_i);
      check("crystal drive", {7'h0, ~xtal}, {7'h0, xdrv});
      check("int crystal", {7'h0, xtal}, {7'h0, int_oe});
    end
  endtask
  task automatic t_ignore();
    logic [7:0] v;
    access(`RTCFE_SEL_YEAR, 1'b0, 8'h12, v);
    host_u.xfer(8'hff, 8, v);
    check("line while idle", 8'hff, v);
    host_u.sel(1'b1);
    host_u.xfer({`RTCFE_CMD_CODE, `RTCFE_SEL_YEAR, 1'b0}, 8, v);
    host_u.xfer(8'h55, 4, v);
    host_u.sel(1'b0);
    host_u.sel(1'b1);
    host_u.xfer(8'hff, 8, v);
    host_u.xfer(8'hff, 8, v);
    host_u.sel(1'b0);
    check("refused command", 8'hff, v);
    access(`RTCFE_SEL_YEAR, 1'b1, 8'h00, v);
    check("year kept", 8'h12, v);
  endtask
  ////////////////////////////////////////
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    rst_i = 1'b1;
    xtal = 1'b0;
    low_sup = 1'b0;
    {user_freq, alarm2, alarm1} = 3'h0;
    repeat (10) @(posedge clock_i);
    rst_i <= 1'b0;
    t_status();
    t_int_source();
    t_xtal();
    t_ignore();
    wrap_up();
  end
endmodule
